// ===== ssd_device.sv
// Device end: shift register, address latch, data latches, divider chain
//
// Overview of operation
// - Shift data on each rising serial clock
// - First step latches 8-bit address
// - Second step latches up to 16 data bits
// - Transfer happens on enable falling edge
// - Enable level during shifting selects destination
// - Host keeps clock still during the enable latch pulse
// - Host sends MSB first, LSB last
// - Host sends only the requested data bits, with no leading zero padding
// - Port usable within 100 us after power-up
// - Port works in every power mode
// - 14-bit transmit and receive counters
// - Power-up defaults for channel 21, 10.24 MHz
// - Control bit switches tank capacitors
// - 12-bit reference divider, max 4095
// - Six-bit cap clock counter, then divide-by-2
// - Modulation is cap clock over 40
// - Both selects zero gives post-divide one
// - Both selects one gives divide-by-4
// - Single select splits transmit/receive references
// - Latched contents kept in all modes
`timescale 1ns/1ps
`default_nettype none
module ssd_device
    import ssd_pkg::*;
#(
    parameter int SHIFT_WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    input wire logic powerMode0,
    input wire logic powerMode1,
    ssd_link_if.device link,
    output logic txReference,
    output logic rxReference,
    output logic switchedCapClock,
    output logic modulationClock,
    output logic tankCapEnable,
    output logic [13:0] txCount,
    output logic [13:0] rxCount,
    output logic [7:0] addressLatch
);
    // Elaboration check: a full data word must fit the shift register
    if (SHIFT_WIDTH < DATA_WIDTH) begin
        $error("SHIFT_WIDTH too small");
    end

    // ****************************************
    // Link edge detection
    // ****************************************
    logic sclkPrev_reg;
    logic enPrev_reg;
    logic modeAddress_reg;
    logic [SHIFT_WIDTH-1:0] shift_reg;
    logic [11:0] refDiv_reg;
    logic [5:0] scfDiv_reg;
    logic [2:0] ctrl_reg;
    logic [13:0] txDiv_reg;
    logic [13:0] rxDiv_reg;
    logic sclkRise;
    logic enFall;
    logic unusedMode;

    // Power mode pins ignored: port stays live in every mode
    assign unusedMode = powerMode0 ^ powerMode1;
    assign sclkRise = link.serialClock && !sclkPrev_reg;
    assign enFall = enPrev_reg && !link.latchEnable;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclkPrev_reg <= 1'b0;
            enPrev_reg <= 1'b0;
        end else if (clockEnable) begin
            sclkPrev_reg <= link.serialClock;
            enPrev_reg <= link.latchEnable;
        end
    end

    // ****************************************
    // Shift register and step tracking
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_reg <= '0;
            modeAddress_reg <= 1'b1;
        end else if (clockEnable) begin
            if (sclkRise) begin
                shift_reg <= {shift_reg[SHIFT_WIDTH-2:0], link.serialData};
                // Enable high marks an address; data shifts low so the pulse sees no edge
                modeAddress_reg <= link.latchEnable;
            end
        end
    end

    // ****************************************
    // Address and data latches
    // ****************************************
    // Latches persist whatever the power mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addressLatch <= '0;
        end else if (clockEnable && enFall && modeAddress_reg) begin
            addressLatch <= shift_reg[ADDR_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            refDiv_reg <= REF_DEFAULT;
            txDiv_reg <= TX_DEFAULT;
            rxDiv_reg <= RX_DEFAULT;
            scfDiv_reg <= SCF_DEFAULT;
            ctrl_reg <= CTRL_DEFAULT;
        end else if (clockEnable && enFall && !modeAddress_reg) begin
            case (addressLatch)
                ADDR_REF: refDiv_reg <= shift_reg[11:0];
                ADDR_TX: txDiv_reg <= shift_reg[13:0];
                ADDR_RX: rxDiv_reg <= shift_reg[13:0];
                ADDR_SCF: scfDiv_reg <= shift_reg[5:0];
                ADDR_CTRL: ctrl_reg <= shift_reg[2:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // ****************************************
    // Divider chain on the reference oscillator
    // ****************************************
    logic [11:0] refCnt_reg;
    logic refTick;
    logic [4:0] txPre_reg;
    logic [4:0] rxPre_reg;
    logic [4:0] txLimit;
    logic [4:0] rxLimit;
    logic [13:0] txCnt_reg;
    logic [13:0] rxCnt_reg;
    logic [5:0] scfCnt_reg;
    logic [5:0] modCnt_reg;
    logic txWrap;
    logic rxWrap;

    // Divide-by-zero treated as one to keep the chain alive
    assign refTick = (refCnt_reg <= 12'h001);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            refCnt_reg <= REF_DEFAULT;
        end else if (clockEnable) begin
            refCnt_reg <= refTick ? refDiv_reg : refCnt_reg - 12'h001;
        end
    end

    // Post-divider limits per select bit pair
    always_comb begin
        case ({ctrl_reg[CTRL_HANDSET_BIT], ctrl_reg[CTRL_BASE_BIT]})
            2'b00: begin
                txLimit = 5'd1;
                rxLimit = 5'd1;
            end
            2'b11: begin
                txLimit = 5'(PREDIV_QUARTER);
                rxLimit = 5'(PREDIV_QUARTER);
            end
            2'b01: begin
                txLimit = 5'(PREDIV_QUARTER);
                rxLimit = 5'(PREDIV_UK);
            end
            default: begin
                txLimit = 5'(PREDIV_UK);
                rxLimit = 5'(PREDIV_QUARTER);
            end
        endcase
    end

    assign txWrap = (txPre_reg + 5'h01 >= txLimit);
    assign rxWrap = (rxPre_reg + 5'h01 >= rxLimit);

    // One pulse per reference period; a total ratio of one holds it high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txPre_reg <= '0;
            rxPre_reg <= '0;
            txReference <= 1'b0;
            rxReference <= 1'b0;
        end else if (clockEnable) begin
            txReference <= refTick && txWrap;
            rxReference <= refTick && rxWrap;
            if (refTick) begin
                txPre_reg <= txWrap ? 5'h00 : txPre_reg + 5'h01;
                rxPre_reg <= rxWrap ? 5'h00 : rxPre_reg + 5'h01;
            end
        end
    end

    // Channel counters step on every enabled clock cycle (VCO stand-in)
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txCnt_reg <= '0;
            rxCnt_reg <= '0;
        end else if (clockEnable) begin
            txCnt_reg <= (txCnt_reg + 14'd1 >= txDiv_reg) ? 14'd0 : txCnt_reg + 14'd1;
            rxCnt_reg <= (rxCnt_reg + 14'd1 >= rxDiv_reg) ? 14'd0 : rxCnt_reg + 14'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txCount <= '0;
            rxCount <= '0;
            tankCapEnable <= 1'b0;
        end else if (clockEnable) begin
            txCount <= txCnt_reg;
            rxCount <= rxCnt_reg;
            tankCapEnable <= ctrl_reg[CTRL_TANKCAP_BIT];
        end
    end

    // Switched-cap clock: programmable count then toggle (divide by 2)
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scfCnt_reg <= '0;
            switchedCapClock <= 1'b0;
            modCnt_reg <= '0;
            modulationClock <= 1'b0;
        end else if (clockEnable) begin
            if (scfCnt_reg + 6'd1 >= scfDiv_reg) begin
                scfCnt_reg <= '0;
                switchedCapClock <= !switchedCapClock;
                if (!switchedCapClock) begin
                    if (modCnt_reg + 6'd1 >= 6'(MOD_DIVIDE / 2)) begin
                        modCnt_reg <= '0;
                        modulationClock <= !modulationClock;
                    end else begin
                        modCnt_reg <= modCnt_reg + 6'd1;
                    end
                end
            end else begin
                scfCnt_reg <= scfCnt_reg + 6'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== ssd_pkg.sv
// Package for the serial synthesizer divider programming port
package ssd_pkg;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 16;
    localparam logic [7:0] ADDR_REF = 8'h01;
    localparam logic [7:0] ADDR_TX = 8'h02;
    localparam logic [7:0] ADDR_RX = 8'h03;
    localparam logic [7:0] ADDR_SCF = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h05;
    // Control register fields
    localparam int CTRL_BASE_BIT = 0;
    localparam int CTRL_HANDSET_BIT = 1;
    localparam int CTRL_TANKCAP_BIT = 2;
    // Defaults: channel 21 with 10.24 MHz crystal
    localparam logic [11:0] REF_DEFAULT = 12'h800;
    localparam logic [13:0] TX_DEFAULT = 14'h0D06;
    localparam logic [13:0] RX_DEFAULT = 14'h0A4C;
    localparam logic [5:0] SCF_DEFAULT = 6'h1F;
    localparam logic [2:0] CTRL_DEFAULT = 3'h0;
    localparam int MOD_DIVIDE = 40;
    localparam int PREDIV_QUARTER = 4;
    localparam int PREDIV_UK = 25;
    // Power-up wait before first transfer
    localparam int POWERUP_US = 100;
    localparam int CLOCK_MHZ = 100;
    localparam int POWERUP_CYCLES = POWERUP_US * CLOCK_MHZ;
    localparam int HOST_HALF_PERIOD = 4;
endpackage

// ===== ssd_link_if.sv
// Three-wire programming link between host and device
`timescale 1ns/1ps
`default_nettype none
interface ssd_link_if;
    logic serialData;
    logic serialClock;
    logic latchEnable;
    modport host (output serialData, output serialClock, output latchEnable);
    modport device (input serialData, input serialClock, input latchEnable);
endinterface
`default_nettype wire

// ===== ssd_host.sv
// Host end: waits after power-up, then sends address and data words
`timescale 1ns/1ps
`default_nettype none
module ssd_host
    import ssd_pkg::*;
#(
    parameter int POWERUP_WAIT = POWERUP_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    input wire logic writeRequest,
    input wire logic [7:0] writeAddress,
    input wire logic [15:0] writeData,
    input wire logic [4:0] writeDataBits,
    ssd_link_if.host link,
    output logic busy,
    output logic ready
);
    // Elaboration check: the wait counter needs at least one cycle
    if (POWERUP_WAIT < 1) begin
        $error("POWERUP_WAIT must be positive");
    end

    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LATCH = 3'b011,
        ST_GAP = 3'b100
    } ssd_state_type;

    ssd_state_type state_reg;
    logic [31:0] wait_reg;
    logic [15:0] word_reg;
    logic [4:0] bitsLeft_reg;
    logic [2:0] phase_reg;
    logic dataStep_reg;
    logic [15:0] data_reg;
    logic [4:0] dataBits_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_WAIT;
            wait_reg <= '0;
            word_reg <= '0;
            bitsLeft_reg <= '0;
            phase_reg <= '0;
            dataStep_reg <= 1'b0;
            data_reg <= '0;
            dataBits_reg <= '0;
            link.serialData <= 1'b0;
            link.serialClock <= 1'b0;
            link.latchEnable <= 1'b0;
            busy <= 1'b1;
            ready <= 1'b0;
        end else if (clockEnable) begin
            case (state_reg)
                ST_WAIT: begin
                    // No transfer before the port is alive
                    if (wait_reg + 32'd1 >= 32'(POWERUP_WAIT)) begin
                        state_reg <= ST_IDLE;
                        busy <= 1'b0;
                        ready <= 1'b1;
                    end
                    wait_reg <= wait_reg + 32'd1;
                end
                ST_IDLE: begin
                    if (writeRequest) begin
                        word_reg <= {writeAddress, 8'h00};
                        bitsLeft_reg <= 5'(ADDR_WIDTH);
                        data_reg <= writeData;
                        dataBits_reg <= (writeDataBits > 5'(DATA_WIDTH) || writeDataBits == 5'd0)
                            ? 5'(DATA_WIDTH) : writeDataBits;
                        dataStep_reg <= 1'b0;
                        phase_reg <= '0;
                        state_reg <= ST_SHIFT;
                        busy <= 1'b1;
                        ready <= 1'b0;
                    end
                end
                ST_SHIFT: begin
                    phase_reg <= phase_reg + 3'd1;
                    if (phase_reg == 3'd0) begin
                        link.serialData <= word_reg[15];
                        link.serialClock <= 1'b0;
                        // Address shifts with enable high, data with it low
                        link.latchEnable <= !dataStep_reg;
                    end else if (phase_reg == 3'(HOST_HALF_PERIOD)) begin
                        link.serialClock <= 1'b1;
                        word_reg <= {word_reg[14:0], 1'b0};
                        bitsLeft_reg <= bitsLeft_reg - 5'd1;
                    end else if (phase_reg == 3'(HOST_HALF_PERIOD + 3)) begin
                        link.serialClock <= 1'b0;
                        phase_reg <= '0;
                        if (bitsLeft_reg == 5'd0) begin
                            state_reg <= ST_LATCH;
                        end
                    end
                end
                ST_LATCH: begin
                    // Pulse enable with clock held still
                    phase_reg <= phase_reg + 3'd1;
                    if (phase_reg == 3'd0) begin
                        link.latchEnable <= 1'b1;
                    end else if (phase_reg == 3'd3) begin
                        link.latchEnable <= 1'b0;
                        phase_reg <= '0;
                        state_reg <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (!dataStep_reg) begin
                        // Left-aligned so the top requested data bit is sent first
                        word_reg <= data_reg << (5'(DATA_WIDTH) - dataBits_reg);
                        bitsLeft_reg <= dataBits_reg;
                        dataStep_reg <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end else begin
                        state_reg <= ST_IDLE;
                        busy <= 1'b0;
                        ready <= 1'b1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== ssd_link_chk.sv
// Assertions on the host-driven programming link
`timescale 1ns/1ps
`default_nettype none
module ssd_link_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serialData,
    input wire logic serialClock,
    input wire logic latchEnable,
    input wire logic ready,
    input wire logic busy,
    input wire logic [7:0] addressLatch
);
    // ****************
    // Helper state
    // ****************
    logic [15:0] shiftWord_reg;
    logic [4:0] bitCount_reg;
    logic [3:0] sinceFall_reg;
    logic seenReady_reg;
    logic addrMode_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shiftWord_reg <= 16'h0000;
            bitCount_reg <= 5'h00;
            addrMode_reg <= 1'b0;
        end else if ($fell(latchEnable)) begin
            bitCount_reg <= 5'h00;
        end else if ($rose(serialClock)) begin
            shiftWord_reg <= {shiftWord_reg[14:0], serialData};
            bitCount_reg <= bitCount_reg + 5'h01;
            addrMode_reg <= latchEnable;
        end
    end
    // Saturates so a long idle never wraps back into the window
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sinceFall_reg <= 4'hF;
            seenReady_reg <= 1'b0;
        end else begin
            if ($fell(latchEnable)) begin
                sinceFall_reg <= 4'h0;
            end else if (sinceFall_reg != 4'hF) begin
                sinceFall_reg <= sinceFall_reg + 4'h1;
            end
            if (ready) begin
                seenReady_reg <= 1'b1;
            end
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_data_held_rise: assert property ($rose(serialClock) |-> $stable(serialData))
        else $error("data moved at clock rise");
    a_clock_high_three: assert property (
        $rose(serialClock) |-> serialClock [*3] ##1 !serialClock)
        else $error("clock high time wrong");
    a_quiet_clock_en: assert property (
        latchEnable && !addrMode_reg && bitCount_reg != 5'h00 |-> $stable(serialClock))
        else $error("clock edge while enable high");
    a_latch_pulse_len: assert property (
        $rose(latchEnable) && !addrMode_reg && bitCount_reg != 5'h00 |->
            latchEnable [*3] ##1 !latchEnable)
        else $error("enable pulse length wrong");
    a_quiet_before_ready: assert property (
        !seenReady_reg |-> !serialClock && !latchEnable)
        else $error("link active before ready");
    a_ready_busy_excl: assert property (seenReady_reg |-> ready != busy)
        else $error("ready and busy agree");
    a_word_length_ok: assert property (
        $fell(latchEnable) |-> bitCount_reg inside {[5'h01:5'h10]})
        else $error("word length out of range");
    a_addr_eight_bits: assert property (
        $fell(latchEnable) && addrMode_reg |-> bitCount_reg == 5'h08)
        else $error("address word not eight bits");
    a_addr_gets_word: assert property (
        $fell(latchEnable) && addrMode_reg |-> ##[1:3] addressLatch == shiftWord_reg[7:0])
        else $error("address latch missed word");
    a_addr_held_still: assert property (!$stable(addressLatch) |-> sinceFall_reg <= 4'h3)
        else $error("address latch moved without latch");
endmodule
`default_nettype wire

// ===== serial_synth_divider_control_tb.sv
// Testbench joining host and device ends of the programming link
`timescale 1ns/1ps
`default_nettype none
module serial_synth_divider_control_tb;
    import ssd_pkg::*;
    localparam int WAIT_CYCLES = 10;
    localparam int LIMIT = 6000;
    logic clock, rst_n, powerMode0, powerMode1, writeRequest, busy, ready;
    logic [7:0] writeAddress, addrA, addrB;
    logic [15:0] writeData, monWord;
    logic [4:0] writeDataBits;
    logic txRefB, rxRefB, capClkB, modClkB, tankB, clkSeen, enSeen, clkEnB;
    logic [13:0] txCntB, rxCntB;
    int cntV;
    logic [15:0] wordQ[$];
    int bitsQ[$];
    int monBits, miscompares, cmp_count;
    logic [15:0] ctrlTab [4] = '{16'h0000, 16'h0007, 16'h0001, 16'h0006};
    int txTab [4] = '{10, 40, 40, 250};
    int rxTab [4] = '{10, 40, 250, 40};
    ssd_link_if linkA ();
    ssd_link_if linkB ();
    ssd_host #(.POWERUP_WAIT(WAIT_CYCLES)) u_ssd_host (.clock(clock), .rst_n(rst_n),
        .clockEnable(1'b1), .writeRequest(writeRequest), .writeAddress(writeAddress),
        .writeData(writeData), .writeDataBits(writeDataBits), .link(linkA),
        .busy(busy), .ready(ready));
    ssd_device u_ssd_device (.clock(clock), .rst_n(rst_n), .clockEnable(1'b1),
        .powerMode0(powerMode0), .powerMode1(powerMode1), .link(linkA), .txReference(),
        .rxReference(), .switchedCapClock(), .modulationClock(), .tankCapEnable(),
        .txCount(), .rxCount(), .addressLatch(addrA));
    // Second device driven straight by the bench tasks
    ssd_device u_ssd_device_b (.clock(clock), .rst_n(rst_n), .clockEnable(clkEnB),
        .powerMode0(powerMode0), .powerMode1(powerMode1), .link(linkB),
        .txReference(txRefB), .rxReference(rxRefB), .switchedCapClock(capClkB),
        .modulationClock(modClkB), .tankCapEnable(tankB), .txCount(txCntB),
        .rxCount(rxCntB), .addressLatch(addrB));
    ssd_link_chk u_ssd_link_chk (.clock(clock), .rst_n(rst_n),
        .serialData(linkA.serialData), .serialClock(linkA.serialClock),
        .latchEnable(linkA.latchEnable), .ready(ready), .busy(busy), .addressLatch(addrA));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ****************
    // Wire monitor, sampled mid-cycle where the host's flops are settled
    // ****************
    always @(negedge clock) begin
        if (linkA.serialClock === 1'b1 && clkSeen === 1'b0) begin
            monWord = {monWord[14:0], linkA.serialData};
            monBits++;
        end
        if (linkA.latchEnable === 1'b0 && enSeen === 1'b1) begin
            wordQ.push_back(monWord);
            bitsQ.push_back(monBits);
            monWord = 16'h0000;
            monBits = 0;
        end
        clkSeen = linkA.serialClock;
        enSeen = linkA.latchEnable;
    end
    // ****************
    // Tasks
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_up();
        miscompares++;
        $display("wait ran out at %0t", $time);
        tally_and_finish();
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return txRefB;
            1: return rxRefB;
            2: return capClkB;
            default: return modClkB;
        endcase
    endfunction
    task automatic wait_rise(input int sel, output int n);
        logic prev;
        n = 0;
        do begin
            prev = pick(sel);
            tick(1);
            n++;
        end while (!(prev === 1'b0 && pick(sel) === 1'b1) && n < LIMIT);
        if (n >= LIMIT) give_up();
    endtask
    // Rise to rise spacing in clock cycles
    task automatic measure(input int sel, input int expv);
        int n;
        wait_rise(sel, n);
        wait_rise(sel, n);
        chk(n, expv);
    endtask
    // Eight cycles a bit; enable low while shifting selects a data latch
    task automatic send_word(input logic [15:0] w, input int n, input logic dataMode);
        linkB.latchEnable = !dataMode;
        for (int i = n - 1; i >= 0; i--) begin
            linkB.serialData = w[i];
            tick(4);
            linkB.serialClock = 1'b1;
            tick(3);
            linkB.serialClock = 1'b0;
            tick(1);
        end
        linkB.latchEnable = 1'b1;
        tick(3);
        linkB.latchEnable = 1'b0;
        tick(3);
    endtask
    task automatic wr_b(input logic [7:0] a, input logic [15:0] d);
        send_word({8'h00, a}, 8, 1'b0);
        send_word(d, 16, 1'b1);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        if (n >= 1000) give_up();
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {rst_n, powerMode0, powerMode1, writeRequest} = 4'h0;
        {writeAddress, writeData, writeDataBits} = 29'h0;
        {linkB.serialData, linkB.serialClock, linkB.latchEnable} = 3'h0;
        clkEnB = 1'b1;
        cntV = 0;
        {monWord, monBits, clkSeen, enSeen, miscompares, cmp_count} = '0;
        tick(5);
        rst_n = 1'b1;
        tick(WAIT_CYCLES - 2);
        chk(ready, 1'b0);
        wait_ready();
        chk(ready, 1'b1);
        $display("test power-up wait done");
        for (int i = 0; i < 2; i++) begin
            writeAddress = i ? 8'hC3 : 8'h5A;
            writeData = i ? 16'h8001 : 16'h0123;
            writeDataBits = i ? 5'h00 : 5'h0C;
            writeRequest = 1'b1;
            tick(2);
            writeRequest = 1'b0;
            tick(1);
            wait_ready();
            chk(bitsQ.size(), 2);
            chk(bitsQ.pop_front(), 8);
            chk(wordQ.pop_front(), writeAddress);
            chk(bitsQ.pop_front(), i ? 16 : 12);
            chk(wordQ.pop_front(), writeData);
            chk(addrA, writeAddress);
        end
        $display("test host words done");
        measure(0, 2048);
        measure(1, 2048);
        measure(2, 62);
        measure(3, 2480);
        chk(tankB, 1'b0);
        $display("test defaults done");
        for (int m = 0; m < 4; m++) begin
            {powerMode1, powerMode0} = m[1:0];
            wr_b(ADDR_REF, 16'h000A);
            wr_b(ADDR_CTRL, ctrlTab[m]);
            wr_b(ADDR_SCF, 16'(5 + m));
            measure(0, txTab[m]);
            measure(1, rxTab[m]);
            measure(2, 2 * (5 + m));
            measure(3, 80 * (5 + m));
            chk(tankB, ctrlTab[m][2]);
        end
        {powerMode1, powerMode0} = 2'h0;
        measure(0, 250);
        $display("test modes and dividers done");
        // Channel counters wrap at the programmed value
        wr_b(ADDR_TX, 16'h0007);
        wr_b(ADDR_RX, 16'h000B);
        cntV = txCntB;
        tick(3);
        chk(txCntB, (cntV + 3) % 7);
        cntV = rxCntB;
        tick(11);
        chk(rxCntB, cntV);
        clkEnB = 1'b0;
        cntV = txCntB;
        tick(4);
        chk(txCntB, cntV);
        clkEnB = 1'b1;
        $display("test counters and enable done");
        wr_b(8'h00, 16'hFFFF);
        wr_b(8'h06, 16'h0000);
        measure(0, 250);
        chk(tankB, 1'b1);
        send_word({8'h00, ADDR_CTRL}, 8, 1'b0);
        send_word(16'h0000, 16, 1'b1);
        chk(tankB, 1'b0);
        send_word(16'h0004, 16, 1'b1);
        chk(tankB, 1'b1);
        chk(addrB, ADDR_CTRL);
        wr_b(ADDR_CTRL, 16'h0000);
        wr_b(ADDR_REF, 16'h0FFF);
        measure(0, 4095);
        $display("test latching done");
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        measure(0, 2048);
        chk(addrB, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
